/* File: rtl/mac_tx_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_tx_consts.svh"

module mac_tx_port
  import mac_tx_pkg::*;
#(
  parameter int HALF_100 = `HALF_100_CYC,
  parameter int HALF_10 = `HALF_10_CYC,
  parameter int HALF_RMII = `HALF_RMII_CYC
) (
  input wire logic clock, // System clock, 200 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic linkClk, // Link clock: txClkWire (MII/RGMII) or refClk (RMII)
  mac_tx_if.mac pins, // PHY-facing pins
  input wire macMode_t mode, // Interface mode, quasi-static
  input wire speed_t speed, // Line speed, quasi-static
  input wire logic userValid, // Frame data present
  input wire logic userError, // Error to signal (RGMII)
  input wire logic [3:0] userData // Data, low bits used in RMII
);
  // ****************************************
  // Clock sourcing: RGMII tx clock and RMII reference
  // ****************************************
  logic [9:0] divCnt_q, divCnt_d;
  logic clk_q, clk_d;
  logic [9:0] half;

  always_comb begin
    if (mode == MODE_RMII) begin
      half = 10'(HALF_RMII);
    end else begin
      half = (speed == SPEED_100) ? 10'(HALF_100) : 10'(HALF_10);
    end
    divCnt_d = divCnt_q + 10'h001;
    clk_d = clk_q;
    if (reset) begin
      divCnt_d = '0;
      clk_d = 1'b0;
    end else if (divCnt_q >= half - 10'h001) begin
      divCnt_d = '0;
      clk_d = !clk_q;
    end
  end

  always_ff @(posedge clock) begin
    divCnt_q <= divCnt_d;
    clk_q <= clk_d;
  end

  assign pins.txClkMac = clk_q;
  assign pins.txClkMacOeN = (mode != MODE_RGMII);
  assign pins.refClk = clk_q;

  // ****************************************
  // User inputs into link domain, two flops each
  // ****************************************
  // Limitation: held levels only; user must hold each word for several link
  // clocks because no handshake is offered.
  logic [5:0] s1_q, s2_q;
  logic en_q, en_d;
  logic [3:0] dat_q, dat_d;

  always_comb begin
    en_d = s2_q[5];
    dat_d = (mode == MODE_RMII) ? {2'h0, s2_q[1:0]} : s2_q[3:0];
  end

  always_ff @(posedge linkClk) begin
    s1_q <= {userValid, userError, userData};
    s2_q <= s1_q;
    en_q <= en_d;
    dat_q <= dat_d;
  end

  // ****************************************
  // Shared control line for RGMII
  // ****************************************
  // One flop per edge, combined by XOR: the line moves only with a flop, so
  // the far end never races a gate switched by the link clock itself.
  logic linkRst1_q, linkRst2_q;
  logic ctrlRise_q, ctrlRise_d, ctrlFall_q, ctrlFall_d;

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      linkRst1_q <= 1'b1;
      linkRst2_q <= 1'b1;
    end else begin
      linkRst1_q <= 1'b0;
      linkRst2_q <= linkRst1_q;
    end
  end

  always_comb begin
    // Launched on the rising edge, stands across the falling one: error
    ctrlRise_d = s2_q[4] ^ ctrlFall_q;
    // Launched on the falling edge, stands across the rising one: enable
    ctrlFall_d = en_q ^ ctrlRise_q;
  end

  always_ff @(posedge linkClk or posedge linkRst2_q) begin
    if (linkRst2_q) begin
      ctrlRise_q <= 1'b0;
    end else begin
      ctrlRise_q <= ctrlRise_d;
    end
  end

  always_ff @(negedge linkClk or posedge linkRst2_q) begin
    if (linkRst2_q) begin
      ctrlFall_q <= 1'b0;
    end else begin
      ctrlFall_q <= ctrlFall_d;
    end
  end

  assign pins.txEn = (mode == MODE_RGMII) ? (ctrlRise_q ^ ctrlFall_q) : en_q;
  assign pins.txData = dat_q;
endmodule : mac_tx_port
`default_nettype wire

/* File: rtl/phy_tx_port.sv */
// Contract
// - MII: drive 25/2.5 MHz clock out
// - MII clock phase locked to reference
// - RGMII: MAC sources 25/2.5 MHz clock
// - Reset: clock pin output low
// - Enable sampled on clock rising edge
// - Enable qualifies four or two data bits
// - Enable active high
// - MII nibble taken on rising edge
// - RMII dibit taken on reference clock
// - RGMII nibble taken on MAC clock
`timescale 1ns/1ps
`default_nettype none
`include "mac_tx_consts.svh"

module phy_tx_port
  import mac_tx_pkg::*;
#(
  parameter int HALF_100 = `HALF_100_CYC,
  parameter int HALF_10 = `HALF_10_CYC
) (
  input wire logic clock, // Reference clock, 200 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic linkClk, // Link-side clock: txClkWire or refClk per mode
  mac_tx_if.phy pins, // MAC-facing pins
  input wire macMode_t mode, // Interface mode, quasi-static
  input wire speed_t speed, // Line speed, quasi-static
  output logic frameValid, // Captured enable
  output logic frameError, // Captured error (RGMII only)
  output logic [3:0] frameData // Captured data, low bits in RMII
);
  // ****************************************
  // Transmit clock generation, reference domain
  // ****************************************
  logic [9:0] divCnt_q, divCnt_d;
  logic clkOut_q, clkOut_d;
  logic oeN_q, oeN_d;
  logic [9:0] halfCnt;

  always_comb begin
    halfCnt = (speed == SPEED_100) ? 10'(HALF_100) : 10'(HALF_10);
    divCnt_d = divCnt_q;
    clkOut_d = clkOut_q;
    oeN_d = oeN_q;
    if (reset) begin
      divCnt_d = '0;
      clkOut_d = 1'b0;
      oeN_d = 1'b0;
    end else begin
      // RGMII turns the pin around only after reset; RMII also releases it only after reset
      oeN_d = (mode != MODE_MII);
      // Counter from the reference keeps phase fixed to it
      if (divCnt_q >= halfCnt - 10'h001) begin
        divCnt_d = '0;
        clkOut_d = !clkOut_q;
      end else begin
        divCnt_d = divCnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    divCnt_q <= divCnt_d;
    clkOut_q <= clkOut_d;
    oeN_q <= oeN_d;
  end

  // ****************************************
  // Transmit clock pin
  // ****************************************
  assign pins.txClkPhy = clkOut_q;
  assign pins.txClkPhyOeN = oeN_q;

  // ****************************************
  // Link-side reset
  // ****************************************
  // The link clock stands still while reset is held, so reset must reach the
  // link flops without an edge; it leaves only on a link edge to stay clean.
  logic linkRst1_q, linkRst1_d;
  logic linkRst2_q, linkRst2_d;

  always_comb begin
    linkRst1_d = 1'b0;
    linkRst2_d = linkRst1_q;
  end

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      linkRst1_q <= 1'b1;
      linkRst2_q <= 1'b1;
    end else begin
      linkRst1_q <= linkRst1_d;
      linkRst2_q <= linkRst2_d;
    end
  end

  // ****************************************
  // Link-side capture
  // ****************************************
  logic enRise_q, enRise_d;
  logic errFall_q, errFall_d;
  logic [3:0] dataRise_q, dataRise_d;
  logic [3:0] laneUsed;

  // RMII carries only the two low lanes; the upper ones read as zero
  assign laneUsed = (mode == MODE_RMII) ? 4'h3 : 4'hF;

  always_comb begin
    enRise_d = pins.txEn;
    errFall_d = pins.txEn;
  end

  for (genvar lane = 0; lane < `NIBBLE_W; lane++) begin : g_lane
    assign dataRise_d[lane] = pins.txData[lane] & laneUsed[lane];
  end

  always_ff @(posedge linkClk) begin
    enRise_q <= enRise_d;
    dataRise_q <= dataRise_d;
  end

  // Error is the control level seen at the falling edge
  always_ff @(negedge linkClk) begin
    errFall_q <= errFall_d;
  end

  // ****************************************
  // Handoff: toggle per captured word, two-flop sync
  // ****************************************
  // Limitation: the link clock is a sub-multiple of the reference, so each
  // word stays stable long enough for the synchronised toggle to sample it.
  // A word is held one full link period; the toggle needs three reference
  // cycles to be acted on, hence link periods of at least four cycles.
  logic tog_q, tog_d;
  logic [5:0] word_q, word_d;

  always_comb begin
    tog_d = !tog_q;
    word_d = {enRise_q, (mode == MODE_RGMII) & errFall_q, dataRise_q};
  end

  // Toggle starts from a known level, or the crossing would never see a change
  always_ff @(posedge linkClk or posedge linkRst2_q) begin
    if (linkRst2_q) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  always_ff @(posedge linkClk) begin
    word_q <= word_d;
  end

  // ****************************************
  // Reference-domain capture
  // ****************************************
  logic togS1_q, togS2_q, togS3_q;
  logic wordStrobe;
  logic valid_q, valid_d, err_q, err_d;
  logic [3:0] data_q, data_d;

  // The first stage feeds no logic; the third just remembers the second's last level
  assign wordStrobe = togS2_q ^ togS3_q;

  always_ff @(posedge clock) begin
    togS1_q <= tog_q;
    togS2_q <= togS1_q;
    togS3_q <= togS2_q;
  end

  always_comb begin
    valid_d = valid_q;
    err_d = err_q;
    data_d = data_q;
    if (reset) begin
      valid_d = 1'b0;
      err_d = 1'b0;
      data_d = 4'h0;
    end else if (wordStrobe) begin
      valid_d = word_q[5];
      err_d = word_q[4];
      data_d = word_q[3:0];
    end
  end

  always_ff @(posedge clock) begin
    valid_q <= valid_d;
    err_q <= err_d;
    data_q <= data_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign frameValid = valid_q;
  assign frameError = err_q;
  assign frameData = data_q;
endmodule : phy_tx_port
`default_nettype wire

/* File: shared/mac_tx_consts.svh */
`ifndef MAC_TX_CONSTS_SVH
`define MAC_TX_CONSTS_SVH

// ****************************************
// Clock rates in kHz
// ****************************************
`define SYS_CLK_KHZ 200000
`define TXCLK_100_KHZ 25000
`define TXCLK_10_KHZ 2500
`define REFCLK_RMII_KHZ 50000

// ****************************************
// Derived half-period counts of the system clock
// ****************************************
`define HALF_100_CYC (`SYS_CLK_KHZ / (2 * `TXCLK_100_KHZ))
`define HALF_10_CYC (`SYS_CLK_KHZ / (2 * `TXCLK_10_KHZ))
`define HALF_RMII_CYC (`SYS_CLK_KHZ / (2 * `REFCLK_RMII_KHZ))

// ****************************************
// Data widths per mode
// ****************************************
`define NIBBLE_W 4
`define DIBIT_W 2

`endif

/* File: shared/mac_tx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mac_tx_if;
  logic txClkPhy;
  logic txClkPhyOeN;
  logic txClkMac;
  logic txClkMacOeN;
  logic txClkWire;
  logic refClk;
  logic txEn;
  logic [3:0] txData;

  // Pin level: phy drives while its enable is low, else MAC; weak pulldown otherwise
  assign txClkWire = !txClkPhyOeN ? txClkPhy : (!txClkMacOeN ? txClkMac : 1'b0);

  modport phy (
    output txClkPhy, txClkPhyOeN,
    input txClkWire, refClk, txEn, txData
  );
  modport mac (
    output txClkMac, txClkMacOeN, refClk, txEn, txData,
    input txClkWire
  );
endinterface : mac_tx_if
`default_nettype wire

/* File: shared/mac_tx_pkg.sv */
package mac_tx_pkg;
  typedef enum logic [1:0] {
    MODE_MII = 2'h0,
    MODE_RMII = 2'h1,
    MODE_RGMII = 2'h3
  } macMode_t;

  typedef enum logic {
    SPEED_10 = 1'h0,
    SPEED_100 = 1'h1
  } speed_t;
endpackage : mac_tx_pkg

/* File: testbench/phy_mac_transmit_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_mac_transmit_port_asserts
  import mac_tx_pkg::*;
#(
  parameter int HALF_100 = 4,
  parameter int HALF_10 = 40
) (
  input wire logic clock, // System clock
  input wire logic reset, // Sync, active high
  input wire macMode_t mode, // Interface mode
  input wire speed_t speed, // Line speed
  input wire logic txClkPhyOeN, // Device pin enable, low drives
  input wire logic txClkWire, // Resolved clock pin
  input wire logic refClk, // Shared reference clock
  input wire logic txEn, // Enable or control line
  input wire logic [3:0] txData // Data lines
);
  logic prev_q, prev_d, seen_q, seen_d;
  logic [7:0] halfCnt_q, halfCnt_d;
  wire linkLvl;
  assign linkLvl = (mode == MODE_RMII) ? refClk : txClkWire;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ****
  // Half-period counter
  // ****
  // The first toggle after reset only arms the check: the divider phase is free there
  always_comb begin
    prev_d = txClkWire;
    seen_d = !reset && (seen_q || txClkWire != prev_q);
    halfCnt_d = (txClkWire != prev_q) ? 8'h00 : halfCnt_q + 8'h01;
  end
  always_ff @(posedge clock) begin
    prev_q <= prev_d;
    seen_q <= seen_d;
    halfCnt_q <= halfCnt_d;
  end
  // ****
  // Properties
  // ****
  pinLowReset_a: assert property (disable iff (1'b0) reset |=> !txClkPhyOeN && !txClkWire)
    else $error("clock pin not driven low in reset");
  miiPinOut_a: assert property (mode == MODE_MII |-> !txClkPhyOeN)
    else $error("clock pin not driven in MII");
  pinReleased_a: assert property (mode != MODE_MII && $past(!reset) |-> txClkPhyOeN)
    else $error("clock pin still driven after reset");
  clkHalf_a: assert property (mode != MODE_RMII && seen_q && txClkWire != prev_q |->
    halfCnt_q == 8'((speed == SPEED_100 ? HALF_100 : HALF_10) - 1))
    else $error("transmit clock half period wrong");
  refRate_a: assert property (mode == MODE_RMII && $rose(refClk) |=>
    refClk ##1 !refClk ##1 !refClk ##1 refClk)
    else $error("reference clock not at 50 MHz");
  dataAlign_a: assert property ($changed(txData) |-> $rose(linkLvl))
    else $error("data changed off the rising link edge");
  enAlign_a: assert property (mode != MODE_RGMII && $changed(txEn) |-> $rose(linkLvl))
    else $error("enable changed off the rising link edge");
  ctrlPhase_a: assert property (mode == MODE_RGMII && $changed(txEn) |-> $changed(txClkWire))
    else $error("control line changed off a clock edge");
endmodule : phy_mac_transmit_port_asserts
`default_nettype wire

/* File: testbench/tb_phy_mac_transmit_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_tx_consts.svh"
module tb_phy_mac_transmit_port import mac_tx_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  macMode_t mode = MODE_MII;
  speed_t speed = SPEED_100;
  logic userValid = 1'b0;
  logic userError = 1'b0;
  logic [3:0] userData = 4'h0;
  logic frameValid, frameError;
  logic [3:0] frameData;
  wire linkClk;
  int errors = 0;
  int nTests = 0;
  int cycles = 0;
  mac_tx_if bus ();
  assign linkClk = (mode == MODE_RMII) ? bus.refClk : bus.txClkWire;
  phy_tx_port phy_tx_port_i (.clock(clock), .reset(reset), .linkClk(linkClk), .pins(bus),
    .mode(mode), .speed(speed), .frameValid(frameValid), .frameError(frameError),
    .frameData(frameData));
  mac_tx_port mac_tx_port_i (.clock(clock), .reset(reset), .linkClk(linkClk), .pins(bus),
    .mode(mode), .speed(speed), .userValid(userValid), .userError(userError),
    .userData(userData));
  phy_mac_transmit_port_asserts #(.HALF_100(`HALF_100_CYC), .HALF_10(`HALF_10_CYC))
    phy_mac_transmit_port_asserts_i (.clock(clock), .reset(reset), .mode(mode), .speed(speed),
    .txClkPhyOeN(bus.txClkPhyOeN), .txClkWire(bus.txClkWire), .refClk(bus.refClk),
    .txEn(bus.txEn), .txData(bus.txData));
  // ****
  // Clock and watchdog
  // ****
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Five link edges carry a word from the user pins to the device's handoff
  // register; the sixth and eight reference cycles cover the crossing
  task automatic send(input logic v, input logic e, input logic [3:0] d);
    @(posedge clock);
    #1;
    userValid = v;
    userError = e;
    userData = d;
    repeat (6) @(posedge linkClk);
    repeat (8) @(posedge clock);
    #1;
    check({frameValid, frameError, frameData, 2'h0},
      {v, e & (mode == MODE_RGMII), (mode == MODE_RMII) ? {2'h0, d[1:0]} : d, 2'h0});
  endtask : send
  task automatic run(input macMode_t m, input speed_t s);
    @(posedge clock);
    #1;
    reset = 1'b1;
    mode = m;
    speed = s;
    repeat (8) @(posedge clock);
    #1;
    check({frameValid, frameError, frameData, bus.txClkPhyOeN, bus.txClkWire}, 8'h00);
    reset = 1'b0;
    send(1'b1, 1'b1, 4'hA);
    send(1'b1, 1'b0, 4'h5);
    send(1'b0, 1'b0, 4'h0);
  endtask : run
  // ****
  // Main sequence
  // ****
  initial begin
    macMode_t modes[3];
    modes = '{MODE_MII, MODE_RMII, MODE_RGMII};
    foreach (modes[i]) begin
      for (int s = 1; s >= 0; s--) begin
        run(modes[i], speed_t'(s));
      end
    end
    finish_test();
  end
endmodule : tb_phy_mac_transmit_port
`default_nettype wire
